// ==== hdl/second_reference_input_regs_pkg.sv ====
// constants for the second-reference divider and reference delay register bank
// assumes an 8-bit register access port fed by the serial programming decoder
package second_reference_input_regs_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] SECOND_REFERENCE_INPUT_DIVIDER_CONTROL   = 8'h26;
   localparam logic [7:0] SECOND_REFERENCE_INPUT_FRACTION_HIGH     = 8'h27;
   localparam logic [7:0] SECOND_REFERENCE_INPUT_FRACTION_MID      = 8'h28;
   localparam logic [7:0] SECOND_REFERENCE_INPUT_FRACTION_LOW      = 8'h29;
   localparam logic [7:0] SECOND_REFERENCE_INPUT_INTEGER_DIVIDE    = 8'h2A;
   localparam logic [7:0] SECOND_REFERENCE_INPUT_MODULUS_HIGH      = 8'h2B;
   localparam logic [7:0] SECOND_REFERENCE_INPUT_MODULUS_MID       = 8'h2C;
   localparam logic [7:0] SECOND_REFERENCE_INPUT_MODULUS_LOW       = 8'h2D;
   localparam logic [7:0] FIRST_REF_DELAY_HIGH   = 8'h2E;
   localparam logic [7:0] FIRST_REF_DELAY_LOW    = 8'h2F;
   localparam logic [7:0] SECOND_REF_DELAY_HIGH  = 8'h30;
   localparam logic [7:0] SECOND_REF_DELAY_LOW   = 8'h31;
   localparam int         REG_COUNT              = 12;
   localparam logic [7:0] REG_FIRST              = SECOND_REFERENCE_INPUT_DIVIDER_CONTROL;
   localparam logic [7:0] REG_LAST               = SECOND_REF_DELAY_LOW;

   // -----------------------------------------------------------------
   // control and delay register bit positions
   // -----------------------------------------------------------------
   localparam int CTRL_USE_REGS_BIT  = 7;   // ratio from registers
   localparam int CTRL_INT_ONLY_BIT  = 6;   // modulator bypass
   localparam int CTRL_SDM_RUN_BIT   = 5;   // modulator enable
   localparam int CTRL_FIRST_RX_BIT  = 4;   // first reference receiver on
   localparam int DELAY_MANUAL_BIT   = 7;   // delay word applies

   // -----------------------------------------------------------------
   // reset values and writable masks, index 0 is offset second_reference_input_divider_control
   // -----------------------------------------------------------------
   localparam logic [REG_COUNT-1:0][7:0] REG_RESET =
      {8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h00, 8'h80, 8'h20, 8'h00, 8'h00, 8'h40, 8'h30};
   localparam logic [REG_COUNT-1:0][7:0] REG_MASK =
      {8'hC0, 8'hFF, 8'hC0, 8'hFF, 8'hF0, 8'hFF, 8'hFF, 8'hFC, 8'hF0, 8'hFF, 8'hFF, 8'hF0};

   // -----------------------------------------------------------------
   // field reset values as seen by the divider and delay logic
   // -----------------------------------------------------------------
   localparam logic [19:0] FRACTION_RESET = 20'h40000;   // 262,144
   localparam logic [5:0]  INT_DIV_RESET  = 6'h08;
   localparam logic [18:0] MODULUS_RESET  = 19'h00000;
   localparam logic [8:0]  DELAY_RESET    = 9'h100;
endpackage

// ==== hdl/second_reference_input_divider_and_ref_delay_regs.sv ====
// register bank for the second-reference sigma-delta divider and reference delays
// assumes a decoded byte-wide register port from the serial programming logic
// Contract
// - control bit 7 picks pins or register ratio
// - control bit 6 forces integer-only division
// - control bit 5 low holds modulator, clocks stopped
// - bit 4 low powers down receiver only if allowed
// - 20-bit fraction spread over three registers
// - fraction is signed, default 262,144
// - integer divide bits 7..2, default 8
// - 19-bit modulus over three registers, default zero
// - first delay automatic unless manual bit set
// - first delay word nine bits, default 0x100
// - second delay automatic unless manual bit set
// - second delay word nine bits, same layout
`timescale 1ns/1ns
module second_reference_input_divider_and_ref_delay_regs
   import second_reference_input_regs_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   input  wire logic               regWrEn,
   input  wire logic               regRdEn,
   input  wire logic [7:0]         regAddr,
   input  wire logic [7:0]         regWrData,
   output logic      [7:0]         regRdData,
   input  wire logic [3:0]         refbSelPins,
   input  wire logic               firstRefPdAllow,
   input  wire logic [8:0]         firstRefAutoDelay,
   input  wire logic [8:0]         secondRefAutoDelay,
   output logic                    refbUseRegs,
   output logic      [3:0]         refbPinSel,
   output logic                    refbIntegerOnly,
   output logic                    refbSdmReset,
   output logic                    refbSdmClkEn,
   output logic                    firstRefRxPowerDown,
   output logic signed [19:0]      refbFraction,
   output logic      [5:0]         refbIntDivide,
   output logic      [18:0]        refbModulus,
   output logic                    firstRefDelayManual,
   output logic      [8:0]         firstRefDelay,
   output logic                    secondRefDelayManual,
   output logic      [8:0]         secondRefDelay
);

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [REG_COUNT-1:0][7:0] regs;      // register storage
      logic [7:0]                rdData;    // read answer
      logic                      useRegs;   // ratio source
      logic [3:0]                pinSel;    // sampled selection pins
      logic                      intOnly;   // modulator bypassed
      logic                      sdmReset;  // modulator held
      logic                      sdmClkEn;  // modulator clocks run
      logic                      rxPd;      // first receiver off
      logic [19:0]               frac;      // fraction word
      logic [5:0]                intDiv;    // integer divide
      logic [18:0]               modulus;   // modulus word
      logic                      man1;      // first delay manual
      logic [8:0]                dly1;      // first delay applied
      logic                      man2;      // second delay manual
      logic [8:0]                dly2;      // second delay applied
   } state_t;

   localparam state_t STATE_RESET = '{
      regs:     REG_RESET,
      rdData:   8'h00,
      useRegs:  1'b0,
      pinSel:   4'h0,
      intOnly:  1'b0,
      sdmReset: 1'b0,
      sdmClkEn: 1'b1,
      rxPd:     1'b0,
      frac:     FRACTION_RESET,
      intDiv:   INT_DIV_RESET,
      modulus:  MODULUS_RESET,
      man1:     1'b0,
      dly1:     DELAY_RESET,
      man2:     1'b0,
      dly2:     DELAY_RESET
   };

   state_t stateQ;   // registered state
   state_t stateD;   // next state

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   // true when the address falls in this bank
   function automatic logic isMapped(input logic [7:0] addr);
      return (addr >= REG_FIRST) && (addr <= REG_LAST);
   endfunction

   // storage index of a mapped address
   function automatic logic [3:0] regIndex(input logic [7:0] addr);
      logic [7:0] diff;
      diff = addr - REG_FIRST;
      return diff[3:0];
   endfunction

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   // writes, reads and decoded fields; fields follow the new register image
   always_comb
   begin
      logic [REG_COUNT-1:0][7:0] r;
      r      = stateQ.regs;
      stateD = stateQ;
      // write: only implemented bits take data
      if (regWrEn && isMapped(regAddr))
      begin
         r[regIndex(regAddr)] = regWrData & REG_MASK[regIndex(regAddr)];
      end
      stateD.regs = r;
      // read: unmapped addresses answer zero
      if (regRdEn)
      begin
         if (isMapped(regAddr))
         begin
            stateD.rdData = stateQ.regs[regIndex(regAddr)] & REG_MASK[regIndex(regAddr)];
         end
         else
         begin
            stateD.rdData = 8'h00;
         end
      end
      // ratio source and modulator controls
      stateD.useRegs  = r[0][CTRL_USE_REGS_BIT];
      stateD.pinSel   = refbSelPins;
      stateD.intOnly  = r[0][CTRL_INT_ONLY_BIT];
      stateD.sdmReset = ~r[0][CTRL_SDM_RUN_BIT];
      stateD.sdmClkEn = r[0][CTRL_SDM_RUN_BIT];
      // receiver power-down only when the outside allow bit is set
      stateD.rxPd     = ~r[0][CTRL_FIRST_RX_BIT] & firstRefPdAllow;
      // fraction, signed two's complement
      stateD.frac     = {r[1], r[2], r[3][7:4]};
      stateD.intDiv   = r[4][7:2];
      // modulus: high register bit 7 is not part of the word
      stateD.modulus  = {r[5][6:0], r[6], r[7][7:4]};
      // delays: manual word or the automatic choice
      stateD.man1     = r[8][DELAY_MANUAL_BIT];
      stateD.dly1     = stateD.man1 ? {r[8][6:0], r[9][7:6]} : firstRefAutoDelay;
      stateD.man2     = r[10][DELAY_MANUAL_BIT];
      stateD.dly2     = stateD.man2 ? {r[10][6:0], r[11][7:6]} : secondRefAutoDelay;
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   // single flop bank for all state
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stateQ <= STATE_RESET;
      end
      else
      begin
         stateQ <= stateD;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all from flops
   // -----------------------------------------------------------------
   assign regRdData            = stateQ.rdData;
   assign refbUseRegs          = stateQ.useRegs;
   assign refbPinSel           = stateQ.pinSel;
   assign refbIntegerOnly      = stateQ.intOnly;
   assign refbSdmReset         = stateQ.sdmReset;
   assign refbSdmClkEn         = stateQ.sdmClkEn;
   assign firstRefRxPowerDown  = stateQ.rxPd;
   assign refbFraction         = signed'(stateQ.frac);
   assign refbIntDivide        = stateQ.intDiv;
   assign refbModulus          = stateQ.modulus;
   assign firstRefDelayManual  = stateQ.man1;
   assign firstRefDelay        = stateQ.dly1;
   assign secondRefDelayManual = stateQ.man2;
   assign secondRefDelay       = stateQ.dly2;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   ratioSource_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_DIVIDER_CONTROL) |=> (refbUseRegs == $past(regWrData[7])))
      else $error("ratio source did not follow control write");

   pinFollow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !sys_rst |=> (refbPinSel == $past(refbSelPins)))
      else $error("selection pins not passed through");

   bypassCtl_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_DIVIDER_CONTROL) |=> (refbIntegerOnly == $past(regWrData[6])))
      else $error("bypass did not follow control write");

   sdmHold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_DIVIDER_CONTROL && !regWrData[5]) |=> (refbSdmReset && !refbSdmClkEn))
      else $error("modulator not held after clearing enable");

   rxPowerDown_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !firstRefPdAllow |=> !firstRefRxPowerDown)
      else $error("receiver powered down without allow");

   fracLow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_FRACTION_LOW) |=> (refbFraction[3:0] == $past(regWrData[7:4])))
      else $error("fraction low nibble wrong");

   fracHigh_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_FRACTION_HIGH) |=> ((refbFraction < 0) == $past(regWrData[7])))
      else $error("fraction sign not from top bit");

   intDivide_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_INTEGER_DIVIDE) |=> (refbIntDivide == $past(regWrData[7:2])))
      else $error("integer divide field wrong");

   modHigh_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_MODULUS_HIGH) |=> (refbModulus[18:12] == $past(regWrData[6:0])))
      else $error("modulus high field wrong");

   firstAuto_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!firstRefDelayManual && !$past(sys_rst)) |-> (firstRefDelay == $past(firstRefAutoDelay)))
      else $error("first delay not automatic");

   firstWord_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == FIRST_REF_DELAY_LOW) ##1 firstRefDelayManual
      |-> (firstRefDelay[1:0] == $past(regWrData[7:6])))
      else $error("first delay low bits wrong");

   secondAuto_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (!secondRefDelayManual && !$past(sys_rst)) |-> (secondRefDelay == $past(secondRefAutoDelay)))
      else $error("second delay not automatic");

   secondWord_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REF_DELAY_HIGH && regWrData[7])
      |=> (secondRefDelay[8:2] == $past(regWrData[6:0])))
      else $error("second delay high bits wrong");

   unusedZero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regRdEn && regAddr == SECOND_REFERENCE_INPUT_DIVIDER_CONTROL) |=> (regRdData[3:0] == 4'h0))
      else $error("unused control bits read nonzero");

   // receiver goes down once allowed and the enable is cleared
   rxAllowDown_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_DIVIDER_CONTROL && !regWrData[CTRL_FIRST_RX_BIT] && firstRefPdAllow)
      |=> firstRefRxPowerDown)
      else $error("receiver not powered down when allowed");

   // modulator released when the enable is set
   sdmRun_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_DIVIDER_CONTROL && regWrData[CTRL_SDM_RUN_BIT])
      |=> (!refbSdmReset && refbSdmClkEn))
      else $error("modulator not running after setting enable");

   // middle byte of the fraction
   fracMid_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_FRACTION_MID) |=> (refbFraction[11:4] == $past(regWrData)))
      else $error("fraction middle byte wrong");

   // middle byte of the modulus
   modMid_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_MODULUS_MID) |=> (refbModulus[11:4] == $past(regWrData)))
      else $error("modulus middle byte wrong");

   // low nibble of the modulus
   modLow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REFERENCE_INPUT_MODULUS_LOW) |=> (refbModulus[3:0] == $past(regWrData[7:4])))
      else $error("modulus low nibble wrong");

   // upper first delay bits in manual mode
   firstHigh_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == FIRST_REF_DELAY_HIGH && regWrData[DELAY_MANUAL_BIT])
      |=> (firstRefDelay[8:2] == $past(regWrData[6:0])))
      else $error("first delay high bits wrong");

   // lower second delay bits in manual mode
   secondLow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regWrEn && regAddr == SECOND_REF_DELAY_LOW) ##1 secondRefDelayManual
      |-> (secondRefDelay[1:0] == $past(regWrData[7:6])))
      else $error("second delay low bits wrong");

   // addresses outside the bank answer zero
   unmappedRead_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regRdEn && (regAddr < REG_FIRST || regAddr > REG_LAST)) |=> (regRdData == 8'h00))
      else $error("unmapped read nonzero");

   // fraction high byte reads back as the field shows it
   fracRead_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regRdEn && !regWrEn && regAddr == SECOND_REFERENCE_INPUT_FRACTION_HIGH) |=> (regRdData == refbFraction[19:12]))
      else $error("fraction high read disagrees with field");

   // integer divide reads back with zero low bits
   intRead_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regRdEn && !regWrEn && regAddr == SECOND_REFERENCE_INPUT_INTEGER_DIVIDE) |=> (regRdData == {refbIntDivide, 2'b00}))
      else $error("integer divide read disagrees with field");

   // modulus middle byte reads back as the field shows it
   modRead_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regRdEn && !regWrEn && regAddr == SECOND_REFERENCE_INPUT_MODULUS_MID) |=> (regRdData == refbModulus[11:4]))
      else $error("modulus middle read disagrees with field");

   // manual first delay low bits read back, rest zero
   delayRead_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (regRdEn && !regWrEn && regAddr == FIRST_REF_DELAY_LOW && firstRefDelayManual)
      |=> (regRdData == {firstRefDelay[1:0], 6'h00}))
      else $error("first delay low read disagrees with field");

endmodule

// ==== tb/host_port_model.sv ====
// host side of the byte-wide register port, one transfer per task call
// assumes a single calling process and the rising edge of clk_sys
`timescale 1ns/1ns
module host_port_model (
   input  wire logic       clk_sys,
   output logic            regWrEn,
   output logic            regRdEn,
   output logic [7:0]      regAddr,
   output logic [7:0]      regWrData,
   input  wire logic [7:0] regRdData
);
   // ------------------------------------------------
   // idle port and transfer task
   // ------------------------------------------------
   // idle values at time zero
   initial
   begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
   end

   // drive after an edge, hold to the taking edge, then release
   task automatic xfer(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk_sys);
      regWrEn <= wr;
      regRdEn <= rd;
      regAddr <= a;
      regWrData <= (a == 8'h2B) ? (d & 8'h7F) : d;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
      regRdEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~regWrData;
      @(negedge clk_sys);
      q = regRdData;
   endtask
endmodule

// ==== tb/tb_second_reference_input_divider_and_ref_delay_regs.sv ====
// self-checking bench for the second-reference divider and delay register bank
// assumes the host model drives the register port, the bench the pins
`timescale 1ns/1ns
module tb_second_reference_input_divider_and_ref_delay_regs
   import second_reference_input_regs_pkg::*;
;
   typedef struct packed {logic [7:0] addr; logic [7:0] rst; logic [7:0] wr; logic [7:0] rd;} row_t;
   logic clk_sys = 1'b0, sys_rst = 1'b1, regWrEn, regRdEn, firstRefPdAllow = 1'b0;
   logic [7:0] regAddr, regWrData, regRdData, q;
   logic [3:0] refbSelPins = 4'h0, refbPinSel;
   logic [8:0] firstRefAutoDelay = 9'h0AA, secondRefAutoDelay = 9'h155, firstRefDelay, secondRefDelay;
   logic refbUseRegs, refbIntegerOnly, refbSdmReset, refbSdmClkEn, firstRefRxPowerDown;
   logic firstRefDelayManual, secondRefDelayManual;
   logic signed [19:0] refbFraction;
   logic [5:0] refbIntDivide;
   logic [18:0] refbModulus;
   int err_total = 0, n_checks = 0;
   // reset value, written value, value read back; last two unmapped
   row_t rows [14] = '{
      '{8'h26, 8'h30, 8'hFF, 8'hF0}, '{8'h27, 8'h40, 8'hFF, 8'hFF}, '{8'h28, 8'h00, 8'hFF, 8'hFF},
      '{8'h29, 8'h00, 8'hFF, 8'hF0}, '{8'h2A, 8'h20, 8'hFF, 8'hFC}, '{8'h2B, 8'h80, 8'hFF, 8'h7F},
      '{8'h2C, 8'h00, 8'hFF, 8'hFF}, '{8'h2D, 8'h00, 8'hFF, 8'hF0}, '{8'h2E, 8'h40, 8'hFF, 8'hFF},
      '{8'h2F, 8'h00, 8'hFF, 8'hC0}, '{8'h30, 8'h40, 8'hFF, 8'hFF}, '{8'h31, 8'h00, 8'hFF, 8'hC0},
      '{8'h25, 8'h00, 8'hFF, 8'h00}, '{8'h32, 8'h00, 8'hFF, 8'h00}};

   // ------------------------------------------------
   // clock, parts and helpers
   // ------------------------------------------------
   always #5 clk_sys = ~clk_sys;

   host_port_model i_host (.clk_sys(clk_sys), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData));

   second_reference_input_divider_and_ref_delay_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .refbSelPins(refbSelPins), .firstRefPdAllow(firstRefPdAllow), .firstRefAutoDelay(firstRefAutoDelay),
      .secondRefAutoDelay(secondRefAutoDelay), .refbUseRegs(refbUseRegs), .refbPinSel(refbPinSel),
      .refbIntegerOnly(refbIntegerOnly), .refbSdmReset(refbSdmReset), .refbSdmClkEn(refbSdmClkEn),
      .firstRefRxPowerDown(firstRefRxPowerDown), .refbFraction(refbFraction), .refbIntDivide(refbIntDivide),
      .refbModulus(refbModulus), .firstRefDelayManual(firstRefDelayManual), .firstRefDelay(firstRefDelay),
      .secondRefDelayManual(secondRefDelayManual), .secondRefDelay(secondRefDelay));

   // compare one value and count it
   task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one write through the host model
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.xfer(1'b1, 1'b0, a, d, q);
   endtask

   // control outputs packed as one value
   function automatic logic [19:0] ctl();
      return {15'h0, refbUseRegs, refbIntegerOnly, refbSdmReset, refbSdmClkEn, firstRefRxPowerDown};
   endfunction

   // summary and verdict
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // hang guard
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      err_total++;
      test_done();
   end

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      chk("fraction", 20'h40000, refbFraction);
      chk("intdiv", 20'h8, refbIntDivide);
      chk("modulus", 20'h0, refbModulus);
      chk("control", 20'h2, ctl());
      chk("delay1", 20'h100, firstRefDelay);
      chk("delay2", 20'h100, secondRefDelay);
      @(negedge clk_sys);
      chk("delay1 auto", 20'h0AA, firstRefDelay);
      chk("delay2 auto", 20'h155, secondRefDelay);
      foreach (rows[i])
      begin
         i_host.xfer(1'b0, 1'b1, rows[i].addr, 8'h00, q);
         chk("reset read", rows[i].rst, q);
         wr(rows[i].addr, rows[i].wr);
         i_host.xfer(1'b0, 1'b1, rows[i].addr, 8'h00, q);
         chk("readback", rows[i].rd, q);
      end
      chk("delay1 man", 20'h3FF, {firstRefDelayManual, firstRefDelay});
      chk("delay2 man", 20'h3FF, {secondRefDelayManual, secondRefDelay});
      i_host.xfer(1'b1, 1'b1, 8'h2A, 8'h40, q);
      chk("old read", 20'hFC, q);
      chk("intdiv", 20'h10, refbIntDivide);
      wr(8'h27, 8'h80);
      wr(8'h28, 8'h00);
      wr(8'h29, 8'h1F);
      chk("fraction", 20'h80001, refbFraction);
      chk("negative", 20'h1, {19'h0, refbFraction < 0});
      wr(8'h2C, 8'hA5);
      wr(8'h2D, 8'hCF);
      chk("modulus", 20'h7FA5C, refbModulus);
      wr(8'h2E, 8'h81);
      wr(8'h2F, 8'h80);
      chk("delay1", 20'h006, firstRefDelay);
      wr(8'h30, 8'h00);
      chk("delay2 auto", 20'h155, {secondRefDelayManual, secondRefDelay});
      wr(8'h26, 8'h00);
      chk("control", 20'h04, ctl());
      @(posedge clk_sys);
      firstRefPdAllow <= 1'b1;
      refbSelPins <= 4'hA;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("rx down", 20'h05, ctl());
      chk("pins", 20'hA, refbPinSel);
      wr(8'h26, 8'h20);
      chk("rx allowed", 20'h03, ctl());
      wr(8'h26, 8'hD0);
      chk("control", 20'h1C, ctl());
      // reset in mid-run brings every field back
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      chk("reset control", 20'h2, ctl());
      chk("reset delay1", 20'h100, {firstRefDelayManual, firstRefDelay});
      chk("reset fraction", 20'h40000, refbFraction);
      i_host.xfer(1'b0, 1'b1, 8'h2B, 8'h00, q);
      chk("reset read", 20'h80, q);
      test_done();
   end
endmodule
